//--- core/lcdcd_pkg.sv
// package for the lcd driver command decoder: encodings, reset values, carriers
// assumes a byte-level front end that delivers start, stop and received bytes
// Notes on behaviour
// - reset: sleep on, horizontal, blank, pointers zero, codes zero, page zero.
// - while asleep, commands and ram writes still execute; settings persist.
// - while asleep, outputs grounded, oscillator stopped, reset detection kept.
// - direction 0 steps column, 1 steps bank; bank 5 ignores direction.
// - three-bit bank pointer selects banks 0 to 5; 5 holds icons.
// - mux select 00=1:17, 10=1:26, 01=1:34.
// - bias factor n equals seven minus bias code.
// - blank/invert and all-on bits pick blank, normal, all on, inverse.
// - icons_only shows only icon row; else full matrix plus icons.
// - command page 00 function/ram, 01 display, 10 high voltage.
// - byte 00 is no-op, byte 01 resets page, in every page.
// - page 00: page select, function set, bank load, column load.
// - page 01: mux ratio, display configuration, bias code.
// - page 10: range and pump enable, pump factor.
// - page 10: temperature coefficient, contrast code; 01xxxxxx reserved.
// - data bytes go to ram at current pointers in any page.
// - after each data byte the active pointer advances by one.
// - target voltage is offset plus contrast code times 0.03 V.
// - pump factor 00 two times to 11 five times; reset two times.
// - temperature code selects one of eight coefficients.
// - master reaches only instruction and data holding registers.
// - control msb 1: one byte follows; 0: stream until stop.
// - control bit 6 routes following bytes to ram or decoder.
// - only write to 011110+pin address is answered; all bytes acknowledged.
// - pointers wrap per direction; last address wraps to zero.
package lcdcd_pkg;
  localparam logic [5:0] SLAVE_ADDR_HI   = 6'h1E;
  localparam logic [6:0] COL_LAST        = 7'h7F;
  localparam logic [2:0] BANK_LAST_GFX   = 3'h4;
  localparam logic [2:0] BANK_ICON       = 3'h5;
  localparam logic [1:0] PAGE_FUNC       = 2'h0;
  localparam logic [1:0] PAGE_DISP       = 2'h1;
  localparam logic [1:0] PAGE_HV         = 2'h2;
  localparam logic [7:0] CMD_NOP         = 8'h00;
  localparam logic [7:0] CMD_PAGE_RESET  = 8'h01;
  localparam int         CTL_MORE_BIT    = 7;
  localparam int         CTL_RAM_BIT     = 6;
  localparam int         BUF_DEPTH       = 2;
  // contrast formula in millivolts
  localparam int         VOFF_LOW_MV     = 2940;
  localparam int         VOFF_HIGH_MV    = 6750;
  localparam int         VSTEP_MV        = 30;
  localparam logic       RST_SLEEP       = 1'b1;

  typedef struct packed {
    logic       sleep_mode;
    logic       addr_dir_select;
    logic [1:0] command_page;
    logic [2:0] bank_pointer;
    logic [6:0] column_pointer;
    logic [1:0] mux_ratio_sel;
    logic       blank_or_invert_sel;
    logic       icons_only;
    logic       all_on_bit;
    logic [2:0] bias_code;
    logic       range_high_sel;
    logic       pump_enable;
    logic [1:0] pump_factor_sel;
    logic [2:0] temp_coef_sel;
    logic [6:0] contrast_voltage_code;
  } lcdcd_cfg_t;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } lcdcd_word_t;

  typedef struct packed {
    logic       en;
    logic [2:0] bank;
    logic [6:0] col;
    logic [7:0] data;
  } lcdcd_ram_wr_t;

  typedef enum logic [1:0] {DM_BLANK, DM_NORMAL, DM_ALL_ON, DM_INVERSE} lcdcd_dmode_t;
endpackage : lcdcd_pkg

//--- core/lcdcd_buf.sv
// two-entry valid/ready buffer holding decoded words
// assumes both sides on CLK; ready may be combinational
module lcdcd_buf
  import lcdcd_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire lcdcd_word_t in_word,
  output logic             out_valid,
  input  wire logic        out_ready,
  output lcdcd_word_t      out_word
);
  typedef struct packed {
    lcdcd_word_t [1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } lcdcd_buf_st_t;

  lcdcd_buf_st_t s_r;
  lcdcd_buf_st_t s_nxt;
  logic          push;
  logic          pop;

  initial begin
    if (DEPTH != 2) $error("buffer depth must be 2");
  end

  assign in_ready  = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_word  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_word;
      s_nxt.wp = ~s_r.wp;
    end
    if (pop) s_nxt.rp = ~s_r.rp;
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) s_r <= '0;
    else s_r <= s_nxt;
  end

  a_buf_no_overflow: assert property (@(posedge CLK) disable iff (RST)
    s_r.cnt == 2'h2 |-> !in_ready) else $error("buffer accepts when full");
endmodule : lcdcd_buf

//--- core/lcdcd_top.sv
// command decoder of the lcd driver: bus byte framing, config state, ram steering
// assumes the serial front end gives clean one-cycle start/stop/byte strobes on CLK
module lcdcd_top
  import lcdcd_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RST,
  input  wire logic          BUS_START,
  input  wire logic          BUS_STOP,
  input  wire logic          BUS_BYTE_VALID,
  input  wire logic [7:0]    BUS_BYTE,
  input  wire logic          ADDR_SELECT_PIN,
  output logic               BUS_ACK,
  output logic               BUS_BYTE_READY,
  output lcdcd_cfg_t         CFG,
  output lcdcd_ram_wr_t      RAM_WR,
  output lcdcd_dmode_t       DISPLAY_MODE,
  output logic [2:0]         BIAS_FACTOR,
  output logic [13:0]        VLCD_TARGET_MV,
  output logic               OUTPUTS_GROUNDED,
  output logic               OSC_ENABLE,
  output logic               POR_DETECT_EN
);
  import lcdcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser for the address select strap

  logic [2:0] sel_sync_r;
  logic       sel_level_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel_sync_r  <= 3'h0;
      sel_level_r <= 1'b0;
    end else begin
      sel_sync_r <= {sel_sync_r[1:0], ADDR_SELECT_PIN};
      if (sel_sync_r[1] == sel_sync_r[2]) sel_level_r <= sel_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // framing: address, control byte, data byte(s)

  typedef enum logic [2:0] {FR_IDLE, FR_ADDR, FR_CTRL, FR_DATA, FR_STREAM, FR_SKIP} lcdcd_fr_t;

  typedef struct packed {
    lcdcd_fr_t  fr;
    logic       ram_sel;
    logic       ack;
  } lcdcd_fr_st_t;

  lcdcd_fr_st_t f_r;
  lcdcd_fr_st_t f_nxt;
  logic         buf_in_valid;
  logic         buf_in_ready;
  lcdcd_word_t  buf_in_word;
  logic         buf_out_valid;
  lcdcd_word_t  buf_out_word;
  logic         byte_take;

  // bytes stall while the buffer is full, so no word is dropped
  assign BUS_BYTE_READY = (f_r.fr == FR_DATA || f_r.fr == FR_STREAM) ? buf_in_ready : 1'b1;
  assign byte_take      = BUS_BYTE_VALID && BUS_BYTE_READY;
  assign buf_in_valid   = BUS_BYTE_VALID && (f_r.fr == FR_DATA || f_r.fr == FR_STREAM);
  assign buf_in_word    = '{is_data: f_r.ram_sel, value: BUS_BYTE};
  assign BUS_ACK        = f_r.ack;

  always_comb begin
    f_nxt     = f_r;
    f_nxt.ack = 1'b0;
    if (BUS_START) begin
      f_nxt.fr = FR_ADDR;
    end else if (BUS_STOP) begin
      f_nxt.fr = FR_IDLE;
    end else if (byte_take) begin
      case (f_r.fr)
        FR_ADDR: begin
          // write only, address 011110 plus strap level
          if (BUS_BYTE == {SLAVE_ADDR_HI, sel_level_r, 1'b0}) begin
            f_nxt.fr  = FR_CTRL;
            f_nxt.ack = 1'b1;
          end else begin
            f_nxt.fr = FR_SKIP;
          end
        end
        FR_CTRL: begin
          f_nxt.ram_sel = BUS_BYTE[CTL_RAM_BIT];
          f_nxt.fr      = BUS_BYTE[CTL_MORE_BIT] ? FR_DATA : FR_STREAM;
          f_nxt.ack     = 1'b1;
        end
        FR_DATA: begin
          f_nxt.fr  = FR_CTRL;
          f_nxt.ack = 1'b1;
        end
        FR_STREAM: f_nxt.ack = 1'b1;
        default: f_nxt.fr = f_r.fr;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) f_r <= '{fr: FR_IDLE, ram_sel: 1'b0, ack: 1'b0};
    else f_r <= f_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // holding registers between bus and execution

  lcdcd_buf #(
    .DEPTH(BUF_DEPTH)
  ) u_hold (
    .CLK       (CLK),
    .RST       (RST),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_word   (buf_in_word),
    .out_valid (buf_out_valid),
    .out_ready (1'b1),
    .out_word  (buf_out_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execution: commands and ram writes

  function automatic logic [9:0] next_addr(input logic [2:0] bank, input logic [6:0] col,
                                           input logic vert);
    logic [2:0] b;
    logic [6:0] c;
    b = bank;
    c = col;
    if (bank == BANK_ICON || !vert) begin
      c = col + 7'h01;
      if (col == COL_LAST && bank != BANK_ICON) begin
        b = (bank == BANK_LAST_GFX) ? 3'h0 : bank + 3'h1;
      end
    end else begin
      b = (bank >= BANK_LAST_GFX) ? 3'h0 : bank + 3'h1;
      if (bank >= BANK_LAST_GFX) c = col + 7'h01;
    end
    return {b, c};
  endfunction : next_addr

  typedef struct packed {
    lcdcd_cfg_t    cfg;
    lcdcd_ram_wr_t wr;
  } lcdcd_ex_st_t;

  lcdcd_ex_st_t e_r;
  lcdcd_ex_st_t e_nxt;
  logic [7:0]   cb;
  logic [9:0]   adv;

  assign cb  = buf_out_word.value;
  assign adv = next_addr(e_r.cfg.bank_pointer, e_r.cfg.column_pointer,
                         e_r.cfg.addr_dir_select);

  always_comb begin
    e_nxt        = e_r;
    e_nxt.wr.en  = 1'b0;
    // sleep does not gate the decoder at all
    if (buf_out_valid) begin
      if (buf_out_word.is_data) begin
        e_nxt.wr = '{en: 1'b1, bank: e_r.cfg.bank_pointer,
                     col: e_r.cfg.column_pointer, data: cb};
        {e_nxt.cfg.bank_pointer, e_nxt.cfg.column_pointer} = adv;
      end else if (cb == CMD_NOP) begin
        e_nxt.cfg = e_r.cfg;
      end else if (cb == CMD_PAGE_RESET) begin
        e_nxt.cfg.command_page = PAGE_FUNC;
      end else begin
        case (e_r.cfg.command_page)
          PAGE_FUNC: begin
            if (cb[7]) e_nxt.cfg.column_pointer = cb[6:0];
            else if (cb[7:2] == 6'h02) e_nxt.cfg.command_page = cb[1:0];
            else if (cb[7:3] == 5'h04 && !cb[0]) begin
              e_nxt.cfg.sleep_mode      = cb[2];
              e_nxt.cfg.addr_dir_select = cb[1];
            end else if (cb[7:3] == 5'h08) e_nxt.cfg.bank_pointer = cb[2:0];
          end
          PAGE_DISP: begin
            if (cb[7:2] == 6'h01) e_nxt.cfg.mux_ratio_sel = cb[1:0];
            else if (cb[7:3] == 5'h01) begin
              e_nxt.cfg.blank_or_invert_sel = cb[2];
              e_nxt.cfg.icons_only          = cb[1];
              e_nxt.cfg.all_on_bit          = cb[0];
            end else if (cb[7:3] == 5'h02) e_nxt.cfg.bias_code = cb[2:0];
          end
          PAGE_HV: begin
            if (cb[7]) e_nxt.cfg.contrast_voltage_code = cb[6:0];
            else if (cb[7:2] == 6'h01) begin
              e_nxt.cfg.range_high_sel = cb[1];
              e_nxt.cfg.pump_enable    = cb[0];
            end else if (cb[7:2] == 6'h02) e_nxt.cfg.pump_factor_sel = cb[1:0];
            else if (cb[7:3] == 5'h04) e_nxt.cfg.temp_coef_sel = cb[2:0];
          end
          default: e_nxt.cfg = e_r.cfg;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      e_r                <= '0;
      e_r.cfg.sleep_mode <= RST_SLEEP;
    end else begin
      e_r <= e_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived outputs

  logic [13:0] vlcd_r;
  logic [13:0] vlcd_nxt;

  always_comb begin
    vlcd_nxt = 14'((e_r.cfg.range_high_sel ? VOFF_HIGH_MV : VOFF_LOW_MV)
             + int'(e_r.cfg.contrast_voltage_code) * VSTEP_MV);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) vlcd_r <= 14'(VOFF_LOW_MV);
    else vlcd_r <= vlcd_nxt;
  end

  assign CFG              = e_r.cfg;
  assign RAM_WR           = e_r.wr;
  assign BIAS_FACTOR      = 3'h7 - e_r.cfg.bias_code;
  // enum order blank, normal, all on, inverse packs as {all_on, blank_or_invert}
  assign DISPLAY_MODE     = lcdcd_dmode_t'({e_r.cfg.all_on_bit,
                                            e_r.cfg.blank_or_invert_sel});
  assign VLCD_TARGET_MV   = vlcd_r;
  assign OUTPUTS_GROUNDED = e_r.cfg.sleep_mode;
  assign OSC_ENABLE       = !e_r.cfg.sleep_mode;
  assign POR_DETECT_EN    = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_data_word;
    buf_out_valid && buf_out_word.is_data;
  endsequence

  a_reset_state: assert property (@(posedge CLK) $fell(RST) |->
    CFG.sleep_mode && CFG.command_page == 2'h0 && CFG.pump_factor_sel == 2'h0)
    else $error("reset state wrong");
  a_ram_write_next: assert property (@(posedge CLK) disable iff (RST)
    s_data_word |=> RAM_WR.en && RAM_WR.bank == $past(CFG.bank_pointer))
    else $error("ram write missing");
  a_horiz_advance: assert property (@(posedge CLK) disable iff (RST)
    s_data_word ##0 (!CFG.addr_dir_select && CFG.column_pointer != COL_LAST)
    |=> CFG.column_pointer == $past(CFG.column_pointer) + 7'h01)
    else $error("column not advanced");
  a_vert_wrap: assert property (@(posedge CLK) disable iff (RST)
    s_data_word ##0 (CFG.addr_dir_select && CFG.bank_pointer == BANK_LAST_GFX)
    |=> CFG.bank_pointer == 3'h0) else $error("bank did not wrap");
  a_page_reset: assert property (@(posedge CLK) disable iff (RST)
    buf_out_valid && !buf_out_word.is_data && buf_out_word.value == CMD_PAGE_RESET
    |=> CFG.command_page == PAGE_FUNC) else $error("page not reset");
  a_bias_map: assert property (@(posedge CLK) disable iff (RST)
    BIAS_FACTOR + CFG.bias_code == 3'h7) else $error("bias factor wrong");
  a_sleep_ground: assert property (@(posedge CLK) disable iff (RST)
    CFG.sleep_mode |-> OUTPUTS_GROUNDED && !OSC_ENABLE) else $error("sleep outputs");
  a_addr_ack: assert property (@(posedge CLK) disable iff (RST)
    f_r.fr == FR_ADDR && byte_take && !BUS_START && !BUS_STOP
    && BUS_BYTE != {SLAVE_ADDR_HI, sel_level_r, 1'b0} |=> !BUS_ACK)
    else $error("foreign address acked");
  a_vlcd_value: assert property (@(posedge CLK) disable iff (RST)
    !CFG.range_high_sel && $stable(CFG) |=> VLCD_TARGET_MV
    == 14'(VOFF_LOW_MV + int'($past(CFG.contrast_voltage_code)) * VSTEP_MV))
    else $error("vlcd target wrong");
endmodule : lcdcd_top

//--- tb/lcdcd_master.sv
// bus master model: start/stop pulses and bytes offered by valid/ready
// assumes the decoder clock CLK; every change lands just after a rising edge
module lcdcd_master (
  input  wire logic       CLK,
  output logic            BUS_START,
  output logic            BUS_STOP,
  output logic            BUS_BYTE_VALID,
  output logic [7:0]      BUS_BYTE,
  input  wire logic       BUS_BYTE_READY,
  input  wire logic       BUS_ACK
);
  timeunit 1ns;
  timeprecision 1ps;
  int stuck = 0;
  initial begin
    BUS_START      = 1'b0;
    BUS_STOP       = 1'b0;
    BUS_BYTE_VALID = 1'b0;
    BUS_BYTE       = 8'hA5;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cond(input logic stop);
    @(posedge CLK);
    if (stop) BUS_STOP <= 1'b1;
    else BUS_START <= 1'b1;
    @(posedge CLK);
    BUS_STOP  <= 1'b0;
    BUS_START <= 1'b0;
  endtask : cond
  // byte held with valid until the edge where ready was seen high
  task automatic put(input logic [7:0] b, output logic ack);
    logic rdy;
    rdy = 1'b0;
    BUS_BYTE       <= b;
    BUS_BYTE_VALID <= 1'b1;
    for (int i = 0; i < 50 && !rdy; i++) begin
      @(negedge CLK);
      rdy = BUS_BYTE_READY;
      @(posedge CLK);
    end
    if (!rdy) stuck++;
    BUS_BYTE_VALID <= 1'b0;
    // released data shows the inverse so a stale byte never looks valid
    BUS_BYTE       <= ~b;
    @(negedge CLK);
    ack = BUS_ACK;
    @(posedge CLK);
  endtask : put
endmodule : lcdcd_master

//--- tb/test_lcd_driver_command_decoder.sv
// self-checking bench of the command decoder against a queue-based model
// assumes lcdcd_pkg compiled first and the master model in lcdcd_master
module test_lcd_driver_command_decoder;
  import lcdcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          pin = 1'b0;
  logic          bus_start, bus_stop, bus_valid, bus_ready, bus_ack;
  logic [7:0]    bus_byte;
  lcdcd_cfg_t    cfg, m;
  lcdcd_ram_wr_t ram_wr, wq[$];
  lcdcd_dmode_t  display_mode, dm;
  logic [2:0]    bias_factor;
  logic [13:0]   vlcd;
  logic          grounded, osc_en, por_en;
  logic [8:0]    s[$];
  logic [7:0]    c;
  int            fail_count = 0;
  int            tests_run = 0;
  always #2.5 clk = ~clk;
  lcdcd_master mst (.CLK(clk), .BUS_START(bus_start), .BUS_STOP(bus_stop),
    .BUS_BYTE_VALID(bus_valid), .BUS_BYTE(bus_byte), .BUS_BYTE_READY(bus_ready),
    .BUS_ACK(bus_ack));
  lcdcd_top dut (.CLK(clk), .RST(rst), .BUS_START(bus_start), .BUS_STOP(bus_stop),
    .BUS_BYTE_VALID(bus_valid), .BUS_BYTE(bus_byte), .ADDR_SELECT_PIN(pin),
    .BUS_ACK(bus_ack), .BUS_BYTE_READY(bus_ready), .CFG(cfg), .RAM_WR(ram_wr),
    .DISPLAY_MODE(display_mode), .BIAS_FACTOR(bias_factor), .VLCD_TARGET_MV(vlcd),
    .OUTPUTS_GROUNDED(grounded), .OSC_ENABLE(osc_en), .POR_DETECT_EN(por_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask : check
  function automatic logic [8:0] dat();
    return {1'b1, 8'($urandom)};
  endfunction : dat
  ////////////////////////////////////////////////////////////////////////////
  task automatic model_cmd(input logic [7:0] b);
    if (b == CMD_PAGE_RESET) m.command_page = PAGE_FUNC;
    else if (m.command_page == PAGE_FUNC) begin
      if (b[7]) m.column_pointer = b[6:0];
      else if (b[7:3] == 5'h08) m.bank_pointer = b[2:0];
      else if (b[7:2] == 6'h02) m.command_page = b[1:0];
      else if (b[7:3] == 5'h04 && !b[0]) {m.sleep_mode, m.addr_dir_select} = b[2:1];
    end else if (m.command_page == PAGE_DISP) begin
      if (b[7:2] == 6'h01) m.mux_ratio_sel = b[1:0];
      else if (b[7:3] == 5'h01) {m.blank_or_invert_sel, m.icons_only, m.all_on_bit} = b[2:0];
      else if (b[7:3] == 5'h02) m.bias_code = b[2:0];
    end else if (m.command_page == PAGE_HV) begin
      if (b[7]) m.contrast_voltage_code = b[6:0];
      else if (b[7:2] == 6'h01) {m.range_high_sel, m.pump_enable} = b[1:0];
      else if (b[7:2] == 6'h02) m.pump_factor_sel = b[1:0];
      else if (b[7:3] == 5'h04) m.temp_coef_sel = b[2:0];
    end
  endtask : model_cmd
  task automatic model_data(input logic [7:0] d);
    wq.push_back({1'b1, m.bank_pointer, m.column_pointer, d});
    if (m.bank_pointer == BANK_ICON || !m.addr_dir_select) begin
      m.column_pointer = m.column_pointer + 7'h01;
      if (m.column_pointer == 7'h00 && m.bank_pointer != BANK_ICON)
        m.bank_pointer = (m.bank_pointer == BANK_LAST_GFX) ? 3'h0 : m.bank_pointer + 3'h1;
    end else if (m.bank_pointer == BANK_LAST_GFX) begin
      m.bank_pointer   = 3'h0;
      m.column_pointer = m.column_pointer + 7'h01;
    end else m.bank_pointer = m.bank_pointer + 3'h1;
  endtask : model_data
  // write pulses are matched whenever they come, so latency is not assumed
  always @(negedge clk) begin
    if (ram_wr.en === 1'b1) check(ram_wr, wq.size() ? wq.pop_front() : 19'h0);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
    dm = m.blank_or_invert_sel ? (m.all_on_bit ? DM_INVERSE : DM_NORMAL)
                               : (m.all_on_bit ? DM_ALL_ON : DM_BLANK);
    check(cfg, m);
    check(display_mode, dm);
    check(bias_factor, 3'h7 - m.bias_code);
    check(vlcd, (m.range_high_sel ? VOFF_HIGH_MV : VOFF_LOW_MV) + VSTEP_MV * m.contrast_voltage_code);
    check({grounded, osc_en, por_en}, {m.sleep_mode, !m.sleep_mode, 1'b1});
    @(posedge clk);
  endtask : settle
  task automatic xfer(input logic co, input logic [1:0] bad, input logic [8:0] q[$]);
    logic ack;
    pin <= 1'($urandom);
    repeat (5) @(posedge clk);
    mst.cond(1'b0);
    mst.put({SLAVE_ADDR_HI, pin ^ (bad == 2'h1), bad == 2'h2}, ack);
    check(ack, bad == 2'h0);
    foreach (q[i]) begin
      if (co || i == 0) begin
        mst.put({co, q[i][8], 6'h00}, ack);
        check(ack, bad == 2'h0);
      end
      if (bad == 2'h0 && q[i][8]) model_data(q[i][7:0]);
      else if (bad == 2'h0) model_cmd(q[i][7:0]);
      mst.put(q[i][7:0], ack);
      check(ack, bad == 2'h0);
      settle();
    end
    mst.cond(1'b1);
    if (mst.stuck != 0) begin
      fail_count++;
      final_report();
    end
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(73464));
    m            = '0;
    m.sleep_mode = RST_SLEEP;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle();
    $display("test reset done");
    // every code of each field except mux 3, banks 6-7, random contrast and column; page 3 and stray bytes must change nothing
    for (int i = 0; i < 8; i++) begin
      c = 8'(i);
      s = {9'h009, 9'h004 | 9'(c[1:0] == 2'h3 ? 2'h0 : c[1:0]), 9'h008 | 9'(c[2:0]),
           9'h020, 9'h010 | 9'(c[2:0]), 9'h001, 9'h00A, 9'h004 | 9'(c[1:0]),
           9'h008 | 9'(c[1:0]), 9'h020 | 9'(c[2:0]), {2'h1, 7'($urandom)}, 9'h001,
           9'h00B, 9'h085, 9'h001, 9'h003, 9'h000,
           9'h020 | {6'h00, c[1:0], 1'b0}, 9'h040 | 9'(i % 6), {2'h1, 7'($urandom)}};
      xfer(1'b0, 2'h0, s);
    end
    $display("test command pages done");
    s = {dat(), 9'h080 | 9'(7'($urandom)), dat(), 9'h000, dat(), 9'h020, dat()};
    xfer(1'b1, 2'h0, s);
    $display("test paired bytes done");
    // wrap corners: last graphic bank, last column, icon bank, both directions
    for (int k = 0; k < 6; k++) begin
      c = (k % 3 == 0) ? 8'h04 : (k % 3 == 1) ? 8'h03 : 8'h05;
      s = {9'h020 | {6'h00, k[0], k[0], 1'b0}, 9'h040 | 9'(c[2:0]),
           (k % 3 == 0) ? 9'h0FE : 9'h0FF};
      xfer(1'b0, 2'h0, s);
      s = {dat(), dat(), dat()};
      xfer(1'b0, 2'h0, s);
    end
    $display("test address walk done");
    for (int b = 1; b < 3; b++) begin
      s = {9'h080, 9'h009};
      xfer(1'b0, 2'(b), s);
    end
    $display("test foreign address done");
    check(wq.size(), 0);
    final_report();
  end
endmodule : test_lcd_driver_command_decoder
